// File: verilog/pfswp_pkg.sv
// Purpose: constants, types and register map of the pin function select
//          block with configuration write protection
// Assumes: AHB-Lite register access, one 32-bit word per register
// Notes:   port A pins sit at pad index 7..0, port B pins at 15..8
package pfswp_pkg;

    localparam int ADDR_W = 8;
    localparam int NPINS = 16;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_PROT = 8'h12;
    localparam logic [7:0] IDX_GPSA0 = 8'h13;
    localparam logic [7:0] IDX_GPSB0 = 8'h15;
    localparam logic [7:0] IDX_GPSB1 = 8'h16;
    localparam logic [ADDR_W-1:0] ADDR_PROT = {IDX_PROT[5:0], 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_GPSA0 = {IDX_GPSA0[5:0], 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_GPSB0 = {IDX_GPSB0[5:0], 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_GPSB1 = {IDX_GPSB1[5:0], 2'h0};

    // reset values and writable-bit masks
    localparam logic [1:0] RST_PROT_FIELD = 2'h0;
    localparam logic [15:0] RST_GPSA0 = 16'h0000;
    localparam logic [15:0] RST_GPSB0 = 16'h0000;
    localparam logic [15:0] RST_GPSB1 = 16'h0000;
    localparam logic [15:0] MASK_GPSA0 = 16'h1F00;
    localparam logic [15:0] MASK_GPSB0 = 16'h7FF5;
    localparam logic [15:0] MASK_GPSB1 = 16'h0001;
    localparam logic [11:0] PROT_PAD_ZERO = 12'h000;
    localparam logic [15:0] UPPER_ZERO = 16'h0000;

    // protection register fields and the meaning of their two bits
    localparam int PROT_CLK_LSB = 2;
    localparam int PROT_MUX_LSB = 0;
    localparam int PROT_ON_BIT = 0;
    localparam int PROT_LOCK_BIT = 1;

    // select field positions
    localparam int SEL_A6 = 12;
    localparam int SEL_A5 = 10;
    localparam int SEL_A4 = 8;
    localparam int SEL_B6 = 13;
    localparam int SEL_B5 = 11;
    localparam int SEL_B4 = 8;
    localparam int SEL_B3 = 6;
    localparam int SEL_B2 = 4;
    localparam int SEL_B1 = 2;
    localparam int SEL_B0 = 0;
    localparam int SEL_B7 = 0;

    // select codes
    localparam logic [2:0] CODE0 = 3'h0;
    localparam logic [2:0] CODE1 = 3'h1;
    localparam logic [2:0] CODE2 = 3'h2;
    localparam logic [2:0] CODE3 = 3'h3;
    localparam logic [2:0] CODE4 = 3'h4;

    // pad indices
    localparam int PIN_A4 = 4;
    localparam int PIN_A5 = 5;
    localparam int PIN_A6 = 6;
    localparam int PIN_B0 = 8;
    localparam int PIN_B1 = 9;
    localparam int PIN_B2 = 10;
    localparam int PIN_B3 = 11;
    localparam int PIN_B4 = 12;
    localparam int PIN_B5 = 13;
    localparam int PIN_B6 = 14;
    localparam int PIN_B7 = 15;

    localparam logic [1:0] HTRANS_IDLE = 2'h0;
    localparam logic HRESP_OKAY = 1'h0;

    typedef enum logic [4:0] {
        FN_NONE,
        FN_PWM_FAULT_IN_0,
        FN_PWM_FAULT_IN_1,
        FN_PWM_FAULT_IN_2,
        FN_PWM_FAULT_IN_3,
        FN_TIMER_A_CH0,
        FN_TIMER_A_CH1,
        FN_TIMER_A_CH2,
        FN_TIMER_A_CH3,
        FN_TIMER_B_CH0,
        FN_PWM_OUT_4,
        FN_PWM_OUT_5,
        FN_PWM_PAIR01_EXT_SOURCE,
        FN_PWM_PAIR23_EXT_SOURCE,
        FN_PWM_PAIR45_EXT_SOURCE,
        FN_SERIAL0_RECEIVE,
        FN_SERIAL0_TRANSMIT,
        FN_SPI0_HOST_OUT,
        FN_SPI0_HOST_IN,
        FN_SPI0_SLAVE_SELECT,
        FN_SPI0_SERIAL_CLOCK,
        FN_I2C_SDA,
        FN_I2C_SCL,
        FN_EXTERNAL_CLOCK_IN,
        FN_CLOCK_OUT_PIN
    } pfswp_fn_e;

    localparam int FN_COUNT = 25;

    // one pad bank: data and output enable per pad
    typedef struct packed {
        logic [NPINS-1:0] dout;
        logic [NPINS-1:0] oe;
    } pfswp_pad_s;

    // peripheral side drive, indexed by function
    typedef struct packed {
        logic [FN_COUNT-1:0] dout;
        logic [FN_COUNT-1:0] oe;
    } pfswp_fn_drive_s;

endpackage

// File: verilog/pfswp_top.sv
// Purpose: pin function select registers with configuration write
//          protection, and the pad mux that they steer
// Assumes: AHB-Lite slave, zero wait states, single word transfers
// Notes:   outputs are registered, so pads follow inputs one cycle late
`timescale 1ns/1ps
module pfswp_top
    import pfswp_pkg::*;
(
    input wire logic ref_clk_i,                 // 40 MHz system clock
    input wire logic rst_i,                     // sync reset, active high
    input wire logic hsel_i,                    // slave select
    input wire logic [31:0] haddr_i,            // byte address
    input wire logic [1:0] htrans_i,            // transfer type
    input wire logic hwrite_i,                  // write strobe
    input wire logic [2:0] hsize_i,             // transfer size
    input wire logic [31:0] hwdata_i,           // write data
    input wire logic hready_i,                  // bus ready
    output logic [31:0] hrdata_o,               // read data
    output logic hreadyout_o,                   // slave ready
    output logic hresp_o,                       // response, always okay
    input wire logic [NPINS-1:0] port_periph_enable_i, // per pad enable
    input wire pfswp_pad_s gpio_drive_i,        // gpio data and enable
    input wire pfswp_fn_drive_s periph_drive_i, // function data and enable
    input wire logic [NPINS-1:0] pad_in_i,      // pad input levels
    output pfswp_pad_s pad_o,                   // pad data and enable
    output logic [NPINS-1:0] gpio_in_o,         // pad levels to gpio
    output logic [FN_COUNT-1:0] periph_in_o,    // pad levels to functions
    output logic clk_ctrl_protect_o,            // clock regs write guard
    output logic mux_ctrl_protect_o,            // mux and port write guard
    output logic clk_ctrl_locked_o,             // clock guard is locked
    output logic mux_ctrl_locked_o              // mux guard is locked
);

    // select decode for one pad
    function automatic pfswp_fn_e pin_func(
        input int p,
        input logic [15:0] a0,
        input logic [15:0] b0,
        input logic [15:0] b1
    );
        logic [2:0] c;
        pfswp_fn_e f;
        c = CODE0;
        f = FN_NONE;
        case (p)
            PIN_A6: begin
                c = 3'(a0[SEL_A6]);
                f = (c == CODE1) ? FN_TIMER_A_CH0 : FN_PWM_FAULT_IN_0;
            end
            PIN_A5: begin
                c = 3'(a0[SEL_A5 +: 2]);
                case (c)
                    CODE0: f = FN_PWM_OUT_5;
                    CODE1: f = FN_PWM_FAULT_IN_2;
                    CODE2: f = FN_TIMER_A_CH3;
                    default: f = FN_NONE;
                endcase
            end
            PIN_A4: begin
                c = 3'(a0[SEL_A4 +: 2]);
                case (c)
                    CODE0: f = FN_PWM_OUT_4;
                    CODE1: f = FN_PWM_FAULT_IN_1;
                    CODE2: f = FN_TIMER_A_CH2;
                    default: f = FN_NONE;
                endcase
            end
            PIN_B6: begin
                c = 3'(b0[SEL_B6 +: 2]);
                case (c)
                    CODE0: f = FN_SERIAL0_RECEIVE;
                    CODE1: f = FN_I2C_SDA;
                    CODE2: f = FN_EXTERNAL_CLOCK_IN;
                    default: f = FN_NONE;
                endcase
            end
            PIN_B5: begin
                c = 3'(b0[SEL_B5 +: 2]);
                case (c)
                    CODE0: f = FN_TIMER_A_CH1;
                    CODE1: f = FN_PWM_FAULT_IN_3;
                    CODE2: f = FN_EXTERNAL_CLOCK_IN;
                    default: f = FN_NONE;
                endcase
            end
            PIN_B4: begin
                c = b0[SEL_B4 +: 3];
                case (c)
                    CODE0: f = FN_TIMER_A_CH0;
                    CODE1: f = FN_CLOCK_OUT_PIN;
                    CODE3: f = FN_TIMER_B_CH0;
                    CODE4: f = FN_PWM_PAIR45_EXT_SOURCE;
                    default: f = FN_NONE;
                endcase
            end
            PIN_B3: begin
                c = 3'(b0[SEL_B3 +: 2]);
                case (c)
                    CODE0: f = FN_SPI0_HOST_OUT;
                    CODE1: f = FN_TIMER_A_CH3;
                    CODE2: f = FN_PWM_PAIR23_EXT_SOURCE;
                    default: f = FN_NONE;
                endcase
            end
            PIN_B2: begin
                c = 3'(b0[SEL_B2 +: 2]);
                case (c)
                    CODE0: f = FN_SPI0_HOST_IN;
                    CODE1: f = FN_TIMER_A_CH2;
                    CODE2: f = FN_PWM_PAIR01_EXT_SOURCE;
                    default: f = FN_NONE;
                endcase
            end
            PIN_B1: begin
                c = 3'(b0[SEL_B1]);
                f = (c == CODE1) ? FN_I2C_SDA : FN_SPI0_SLAVE_SELECT;
            end
            PIN_B0: begin
                c = 3'(b0[SEL_B0]);
                f = (c == CODE1) ? FN_I2C_SCL : FN_SPI0_SERIAL_CLOCK;
            end
            PIN_B7: begin
                c = 3'(b1[SEL_B7]);
                f = (c == CODE1) ? FN_I2C_SCL : FN_SERIAL0_TRANSMIT;
            end
            default: f = FN_NONE;
        endcase
        return f;
    endfunction

    logic wr_q;
    logic [ADDR_W-1:0] addr_q;
    logic [1:0] clk_field_q;
    logic [1:0] mux_field_q;
    logic [15:0] gpsa0_q;
    logic [15:0] gpsb0_q;
    logic [15:0] gpsb1_q;
    logic [31:0] hrdata_q;
    logic hready_q;
    pfswp_pad_s pad_q;
    logic [NPINS-1:0] gpio_in_q;
    logic [FN_COUNT-1:0] periph_in_q;
    logic clk_prot_q;
    logic mux_prot_q;

    // address phase decode
    wire addr_ok = hsel_i && htrans_i[1] && hready_i;
    wire rd_req = addr_ok && !hwrite_i;
    wire [ADDR_W-1:0] haddr_lo = haddr_i[ADDR_W-1:0];

    // data phase write strobes
    wire wr_prot = wr_q && (addr_q == ADDR_PROT);
    wire wr_gpsa0 = wr_q && (addr_q == ADDR_GPSA0);
    wire wr_gpsb0 = wr_q && (addr_q == ADDR_GPSB0);
    wire wr_gpsb1 = wr_q && (addr_q == ADDR_GPSB1);

    // unlocked fields take any written code
    wire [1:0] clk_field_d = (wr_prot && !clk_field_q[PROT_LOCK_BIT]) ?
        hwdata_i[PROT_CLK_LSB +: 2] : clk_field_q;
    wire [1:0] mux_field_d = (wr_prot && !mux_field_q[PROT_LOCK_BIT]) ?
        hwdata_i[PROT_MUX_LSB +: 2] : mux_field_q;

    // select writes blocked by the mux guard
    wire mux_open = !mux_field_q[PROT_ON_BIT];
    wire [15:0] gpsa0_d = (wr_gpsa0 && mux_open) ?
        (hwdata_i[15:0] & MASK_GPSA0) : gpsa0_q;
    wire [15:0] gpsb0_d = (wr_gpsb0 && mux_open) ?
        (hwdata_i[15:0] & MASK_GPSB0) : gpsb0_q;
    wire [15:0] gpsb1_d = (wr_gpsb1 && mux_open) ?
        (hwdata_i[15:0] & MASK_GPSB1) : gpsb1_q;

    // read mux uses next values so a read right after a write sees it
    // reserved and unmapped bits read zero
    wire [15:0] prot_d = {PROT_PAD_ZERO, clk_field_d, mux_field_d};
    wire [15:0] rd_word =
        (haddr_lo == ADDR_PROT) ? prot_d :
        (haddr_lo == ADDR_GPSA0) ? gpsa0_d :
        (haddr_lo == ADDR_GPSB0) ? gpsb0_d :
        (haddr_lo == ADDR_GPSB1) ? gpsb1_d : UPPER_ZERO;
    wire [31:0] hrdata_d = rd_req ? {UPPER_ZERO, rd_word} : hrdata_q;

    // pad mux
    pfswp_fn_e pin_fn [NPINS];
    logic [NPINS-1:0] pad_dout_d;
    logic [NPINS-1:0] pad_oe_d;
    logic [NPINS-1:0] fn_hit [FN_COUNT];
    logic [FN_COUNT-1:0] periph_in_d;

    for (genvar p = 0; p < NPINS; p++) begin : g_pin
        assign pin_fn[p] = pin_func(p, gpsa0_q, gpsb0_q, gpsb1_q);
        wire has_fn = (pin_fn[p] != FN_NONE);
        wire fn_dout = has_fn && periph_drive_i.dout[pin_fn[p]];
        wire fn_oe = has_fn && periph_drive_i.oe[pin_fn[p]];
        assign pad_dout_d[p] = port_periph_enable_i[p] ? fn_dout :
            gpio_drive_i.dout[p];
        assign pad_oe_d[p] = port_periph_enable_i[p] ? fn_oe :
            gpio_drive_i.oe[p];
    end

    for (genvar f = 0; f < FN_COUNT; f++) begin : g_fn
        for (genvar p = 0; p < NPINS; p++) begin : g_hit
            assign fn_hit[f][p] = port_periph_enable_i[p] &&
                (pin_fn[p] == pfswp_fn_e'(f)) && (f != 0);
        end
        // inputs from several pads are ored together
        assign periph_in_d[f] = |(fn_hit[f] & pad_in_i);
    end

    // protection fields, reset to off and unlocked
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            clk_field_q <= RST_PROT_FIELD;
            mux_field_q <= RST_PROT_FIELD;
        end else begin
            clk_field_q <= clk_field_d;
            mux_field_q <= mux_field_d;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            gpsa0_q <= RST_GPSA0;
            gpsb0_q <= RST_GPSB0;
            gpsb1_q <= RST_GPSB1;
        end else begin
            gpsa0_q <= gpsa0_d;
            gpsb0_q <= gpsb0_d;
            gpsb1_q <= gpsb1_d;
        end
    end

    // bus slave: zero wait states, always okay
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            wr_q <= 1'h0;
            addr_q <= '0;
            hrdata_q <= '0;
            hready_q <= 1'h1;
        end else begin
            if (hready_i) begin
                wr_q <= addr_ok && hwrite_i;
                addr_q <= haddr_lo;
            end
            hrdata_q <= hrdata_d;
            hready_q <= 1'h1;
        end
    end

    // pads released to gpio input until software steers them
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            pad_q <= '0;
            gpio_in_q <= '0;
            periph_in_q <= '0;
        end else begin
            pad_q <= {pad_dout_d, pad_oe_d};
            gpio_in_q <= pad_in_i;
            periph_in_q <= periph_in_d;
        end
    end

    // guard levels for the registers held elsewhere
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            clk_prot_q <= 1'h0;
            mux_prot_q <= 1'h0;
        end else begin
            clk_prot_q <= clk_field_d[PROT_ON_BIT];
            mux_prot_q <= mux_field_d[PROT_ON_BIT];
        end
    end

    assign hrdata_o = hrdata_q;
    assign hreadyout_o = hready_q;
    assign hresp_o = HRESP_OKAY;
    assign pad_o = pad_q;
    assign gpio_in_o = gpio_in_q;
    assign periph_in_o = periph_in_q;
    assign clk_ctrl_protect_o = clk_prot_q;
    assign mux_ctrl_protect_o = mux_prot_q;
    assign clk_ctrl_locked_o = clk_field_q[PROT_LOCK_BIT];
    assign mux_ctrl_locked_o = mux_field_q[PROT_LOCK_BIT];

    // checks
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    wire ta0_drv = periph_drive_i.dout[FN_TIMER_A_CH0];
    wire [2:0] b4_code = gpsb0_q[SEL_B4 +: 3];

    sequence s_mux_write_open;
        wr_prot && !mux_field_q[PROT_LOCK_BIT];
    endsequence

    property p_mux_takes;
        logic [1:0] v;
        (s_mux_write_open, v = hwdata_i[PROT_MUX_LSB +: 2])
            |=> (mux_field_q == v);
    endproperty

    a_clk_lock_hold:
    assert property (clk_field_q[PROT_LOCK_BIT] |=> $stable(clk_field_q))
        else $error("locked clock guard changed");

    a_mux_lock_hold:
    assert property (mux_field_q[PROT_LOCK_BIT] |=> $stable(mux_field_q))
        else $error("locked mux guard changed");

    a_mux_write_open:
    assert property (p_mux_takes)
        else $error("unlocked mux guard did not take write");

    a_reset_field_off:
    assert property ($past(rst_i) |-> (clk_field_q == RST_PROT_FIELD) &&
        (mux_field_q == RST_PROT_FIELD) && !clk_ctrl_protect_o)
        else $error("guards not off after reset");

    a_select_guarded:
    assert property (wr_gpsb0 && mux_field_q[PROT_ON_BIT] |=>
        $stable(gpsb0_q) ##1 $stable(gpsb0_q) || wr_gpsb0)
        else $error("guarded select register was written");

    a_clk_guard_out:
    assert property (wr_prot && !clk_field_q[PROT_LOCK_BIT] |=>
        clk_ctrl_protect_o == $past(hwdata_i[PROT_CLK_LSB]))
        else $error("clock guard output wrong");

    // the releasing edge still clears the pads, so start one edge later
    a_gpio_owns_pad:
    assert property (!rst_i |=> ((pad_o.oe ^ $past(gpio_drive_i.oe)) &
        ~$past(port_periph_enable_i)) == '0)
        else $error("gpio lost a pad it owns");

    a_a6_timer_path:
    assert property (port_periph_enable_i[PIN_A6] && gpsa0_q[SEL_A6] |=>
        pad_o.dout[PIN_A6] == $past(ta0_drv))
        else $error("pin A6 timer path wrong");

    a_b4_reserved_off:
    assert property (port_periph_enable_i[PIN_B4] && b4_code == CODE2 |=>
        !pad_o.oe[PIN_B4])
        else $error("reserved code drove pin B4");

    a_sda_two_pins:
    assert property (port_periph_enable_i[PIN_B6] &&
        port_periph_enable_i[PIN_B1] &&
        gpsb0_q[SEL_B6 +: 2] == CODE1[1:0] && gpsb0_q[SEL_B1] &&
        (pad_in_i[PIN_B6] || pad_in_i[PIN_B1]) |=> periph_in_o[FN_I2C_SDA])
        else $error("sda input not combined");

    a_read_upper_zero:
    assert property (rd_req && haddr_lo == ADDR_GPSB1 |=>
        hrdata_o[31:1] == '0 && hreadyout_o && !hresp_o)
        else $error("reserved read bits not zero");

endmodule

// File: tb/pfswp_periph_model.sv
// Purpose: stand-in for the peripherals and gpio pad logic at the mux
// Assumes: the bench names per-pad enables and pad levels it wants
// Notes:   drive patterns are fixed so the bench can derive expectations
`timescale 1ns/1ps
module pfswp_periph_model
    import pfswp_pkg::*;
#(
    parameter logic [15:0] GPIO_DOUT = 16'hA5C3,
    parameter logic [15:0] GPIO_OE = 16'h0FF0,
    parameter logic [FN_COUNT-1:0] FN_DOUT = 25'h0AAAAAA
) (
    input wire logic clk_i,                          // system clock
    input wire logic [NPINS-1:0] en_req_i,           // wanted enables
    input wire logic [NPINS-1:0] lvl_req_i,          // wanted pad levels
    output logic [NPINS-1:0] port_periph_enable_o,   // enables to the mux
    output pfswp_pad_s gpio_drive_o,                 // gpio data and enable
    output pfswp_fn_drive_s periph_drive_o,          // function drive
    output logic [NPINS-1:0] pad_in_o                // levels at the pads
);
    assign gpio_drive_o = '{dout: GPIO_DOUT, oe: GPIO_OE};
    assign periph_drive_o = '{dout: FN_DOUT, oe: '1};
    // enables follow the bench, one clock after the ask
    always @(posedge clk_i) begin
        port_periph_enable_o <= en_req_i;
        pad_in_o <= lvl_req_i;
    end
endmodule

// File: tb/pfswp_top_test.sv
// Purpose: self-checking bench for pin function select and protection
// Assumes: zero wait AHB-Lite slave, pad model beside it
// Notes:   each function is identified through its input fan-in bit
`timescale 1ns/1ps
module pfswp_top_test
    import pfswp_pkg::*;
;
    localparam logic [FN_COUNT-1:0] FN_PAT = 25'h0AAAAAA;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = HTRANS_IDLE;
    logic [31:0] haddr = '0;
    logic [31:0] hwdata = '0;
    logic [31:0] hrdata;
    logic [31:0] rd;
    logic rs;
    logic hready;
    logic hresp;
    logic [15:0] en_req = '0;
    logic [15:0] lvl_req = '0;
    logic [15:0] perien;
    logic [15:0] pad_in;
    logic [15:0] gpio_in;
    pfswp_pad_s gdrv;
    pfswp_pad_s pad;
    pfswp_fn_drive_s fdrv;
    logic [FN_COUNT-1:0] pin_f;
    logic clk_p, mux_p, clk_l, mux_l;
    int n_errors = 0;
    int samples_checked = 0;
    int cycles = 0;

    pfswp_top dut_u (.ref_clk_i(clk), .rst_i(rst), .hsel_i(hsel),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
        .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
        .port_periph_enable_i(perien), .gpio_drive_i(gdrv),
        .periph_drive_i(fdrv), .pad_in_i(pad_in), .pad_o(pad),
        .gpio_in_o(gpio_in), .periph_in_o(pin_f),
        .clk_ctrl_protect_o(clk_p), .mux_ctrl_protect_o(mux_p),
        .clk_ctrl_locked_o(clk_l), .mux_ctrl_locked_o(mux_l));

    pfswp_periph_model #(.FN_DOUT(FN_PAT)) model_u (.clk_i(clk),
        .en_req_i(en_req), .lvl_req_i(lvl_req),
        .port_periph_enable_o(perien), .gpio_drive_o(gdrv),
        .periph_drive_o(fdrv), .pad_in_o(pad_in));

    initial begin
        forever #12.5 clk = ~clk;
    end

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            n_errors++;
            tally_and_finish;
        end
    end

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // one single-word transfer: address phase, then data phase
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= HTRANS_IDLE;
        hwdata <= d;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        rd = hrdata;
        rs = hresp;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rdc(input string name, input logic [7:0] a,
                       input logic [31:0] exp);
        bus(1'b0, a, '0);
        check(name, rd, exp);
    endtask

    task automatic settle;
        repeat (4) @(posedge clk);
    endtask

    function automatic logic [31:0] guards();
        return {28'h0, clk_p, mux_p, clk_l, mux_l};
    endfunction

    // walk every code of one select field on one pin
    task automatic run_pin(input logic [7:0] a, input int lsb,
                           input int pin, input pfswp_fn_e f[$]);
        logic [31:0] e;
        for (int c = 0; c < f.size(); c++) begin
            en_req <= '0;
            settle;
            wr(a, c << lsb);
            rdc("sel_reg", a, c << lsb);
            en_req <= 16'h1 << pin;
            lvl_req <= 16'h1 << pin;
            settle;
            e = (f[c] == FN_NONE) ? '0 : 32'h1 << f[c];
            check("fn_in", {7'h0, pin_f}, e);
            check("gpio_in", {16'h0, gpio_in}, 32'h1 << pin);
            if (f[c] == FN_NONE)
                check("pad_oe", {31'h0, pad.oe[pin]}, '0);
            else
                check("pad_out", pad.dout[pin], FN_PAT[f[c]]);
        end
    endtask

    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rdc("prot", ADDR_PROT, '0);
        rdc("gpsa0", ADDR_GPSA0, RST_GPSA0);
        rdc("gpsb0", ADDR_GPSB0, RST_GPSB0);
        rdc("gpsb1", ADDR_GPSB1, RST_GPSB1);
        rdc("unmapped", 8'h50, '0);
        check("pad_gpio", pad, gdrv);
        check("guards", guards(), '0);
        wr(ADDR_PROT, 32'hFFFF_FFF0);
        rdc("prot", ADDR_PROT, '0);
        wr(ADDR_GPSA0, 32'hFFFF_FFFF);
        rdc("gpsa0", ADDR_GPSA0, {16'h0, MASK_GPSA0});
        wr(ADDR_GPSB0, 32'hFFFF_FFFF);
        rdc("gpsb0", ADDR_GPSB0, {16'h0, MASK_GPSB0});
        wr(ADDR_GPSB1, 32'hFFFF_FFFF);
        rdc("gpsb1", ADDR_GPSB1, {16'h0, MASK_GPSB1});
        run_pin(ADDR_GPSA0, SEL_A6, PIN_A6, '{FN_PWM_FAULT_IN_0,
            FN_TIMER_A_CH0});
        run_pin(ADDR_GPSA0, SEL_A5, PIN_A5, '{FN_PWM_OUT_5,
            FN_PWM_FAULT_IN_2, FN_TIMER_A_CH3, FN_NONE});
        run_pin(ADDR_GPSA0, SEL_A4, PIN_A4, '{FN_PWM_OUT_4,
            FN_PWM_FAULT_IN_1, FN_TIMER_A_CH2, FN_NONE});
        run_pin(ADDR_GPSB0, SEL_B6, PIN_B6, '{FN_SERIAL0_RECEIVE,
            FN_I2C_SDA, FN_EXTERNAL_CLOCK_IN, FN_NONE});
        run_pin(ADDR_GPSB0, SEL_B5, PIN_B5, '{FN_TIMER_A_CH1,
            FN_PWM_FAULT_IN_3, FN_EXTERNAL_CLOCK_IN, FN_NONE});
        run_pin(ADDR_GPSB0, SEL_B4, PIN_B4, '{FN_TIMER_A_CH0,
            FN_CLOCK_OUT_PIN, FN_NONE, FN_TIMER_B_CH0,
            FN_PWM_PAIR45_EXT_SOURCE, FN_NONE, FN_NONE, FN_NONE});
        run_pin(ADDR_GPSB0, SEL_B3, PIN_B3, '{FN_SPI0_HOST_OUT,
            FN_TIMER_A_CH3, FN_PWM_PAIR23_EXT_SOURCE, FN_NONE});
        run_pin(ADDR_GPSB0, SEL_B2, PIN_B2, '{FN_SPI0_HOST_IN,
            FN_TIMER_A_CH2, FN_PWM_PAIR01_EXT_SOURCE, FN_NONE});
        run_pin(ADDR_GPSB0, SEL_B1, PIN_B1, '{FN_SPI0_SLAVE_SELECT,
            FN_I2C_SDA});
        run_pin(ADDR_GPSB0, SEL_B0, PIN_B0, '{FN_SPI0_SERIAL_CLOCK,
            FN_I2C_SCL});
        run_pin(ADDR_GPSB1, SEL_B7, PIN_B7, '{FN_SERIAL0_TRANSMIT,
            FN_I2C_SCL});
        en_req <= '0;
        settle;
        wr(ADDR_GPSB0, 32'h2004);
        en_req <= (16'h1 << PIN_B1) | (16'h1 << PIN_B6);
        lvl_req <= 16'h1 << PIN_B6;
        settle;
        check("fan_in", {7'h0, pin_f}, 32'h1 << FN_I2C_SDA);
        check("fan_out", {pad.dout[PIN_B6], pad.dout[PIN_B1]},
            {2{FN_PAT[FN_I2C_SDA]}});
        en_req <= '0;
        wr(ADDR_GPSB1, 32'h0);
        wr(ADDR_PROT, 32'h1);
        rdc("prot", ADDR_PROT, 32'h1);
        check("guards", guards(), 32'h4);
        wr(ADDR_GPSB1, 32'h1);
        check("hresp", {31'h0, rs}, {31'h0, HRESP_OKAY});
        rdc("gpsb1", ADDR_GPSB1, 32'h0);
        wr(ADDR_PROT, 32'h4);
        rdc("prot", ADDR_PROT, 32'h4);
        check("guards", guards(), 32'h8);
        wr(ADDR_GPSB1, 32'h1);
        rdc("gpsb1", ADDR_GPSB1, 32'h1);
        wr(ADDR_PROT, 32'hB);
        rdc("prot", ADDR_PROT, 32'hB);
        check("guards", guards(), 32'h7);
        wr(ADDR_PROT, 32'h0);
        rdc("prot", ADDR_PROT, 32'hB);
        wr(ADDR_GPSB1, 32'h0);
        rdc("gpsb1", ADDR_GPSB1, 32'h1);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rdc("prot", ADDR_PROT, '0);
        check("guards", guards(), '0);
        tally_and_finish;
    end
endmodule
